// ---- dtp_regs.svh ----
// Register indices, field layout, reset values and timing counts of the tuning block
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define DTP_IDX_STEP_B0 10'h1A6
`define DTP_IDX_STEP_B1 10'h1A7
`define DTP_IDX_STEP_B2 10'h1A8
`define DTP_IDX_STEP_B3 10'h1A9
`define DTP_IDX_STEP_B4 10'h1AA
`define DTP_IDX_STEP_B5 10'h1AB
`define DTP_IDX_PHASE_LO 10'h1AC
`define DTP_IDX_PHASE_HI 10'h1AD
`define DTP_IDX_READBACK 10'h1AE

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define DTP_STEP_BYTES 6
`define DTP_STEP_W 48
`define DTP_PHASE_W 14
`define DTP_PHASE_LO_W 8
`define DTP_PHASE_HI_W 6
`define DTP_ACC_TOP 47
`define DTP_ACC_PHASE_LSB 34
`define DTP_IDX_LSB 2

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define DTP_STEP_RST 48'h0000_0000_0000
`define DTP_PHASE_RST 14'h0000
`define DTP_ACC_RST 48'h0000_0000_0000
`define DTP_RDATA_RST 32'h0000_0000
`define DTP_SYNC_DONE 2'h2
`define DTP_STARTUP_STEP_DEF 48'h0010_0000_0000

`endif

// ---- dtp_pkg.sv ----
// Types shared by the tuning and phase block
package dtp_pkg;

   typedef enum logic [2:0]
   {
      DTP_INIT = 3'b001,
      DTP_IDLE = 3'b010,
      DTP_ACK = 3'b100
   } dtp_fsm_t;

   typedef struct packed
   {
      logic read;
      logic write;
      logic [11:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } dtp_avs_req_t;

   typedef struct packed
   {
      logic waitrequest;
      logic [31:0] readdata;
   } dtp_avs_resp_t;

   typedef struct packed
   {
      dtp_fsm_t fsm;
      dtp_avs_resp_t resp;
      logic [47:0] step_word;
      logic [13:0] phase_shift_word;
      logic [3:0] sel_meta;
      logic [3:0] sel_sync;
      logic [1:0] init_cnt;
   } dtp_top_state_t;

   typedef struct packed
   {
      logic [47:0] acc;
      logic [13:0] phase;
   } dtp_acc_state_t;

endpackage

// ---- dtp_accum.sv ----
// Phase accumulator with phase offset adder
`timescale 1ns/100ps
`include "dtp_regs.svh"

module dtp_accum
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [47:0] step_word,
   input wire logic [13:0] phase_shift_word,
   output logic [13:0] phase_word
);

   dtp_pkg::dtp_acc_state_t st_q;
   dtp_pkg::dtp_acc_state_t st_d;

   // ----------------------------------------------------------------
   // Accumulate and offset
   // ----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      // Never cleared on a new step word, so phase stays continuous
      st_d.acc = st_q.acc + step_word;
      st_d.phase = st_q.acc[`DTP_ACC_TOP:`DTP_ACC_PHASE_LSB] + phase_shift_word;
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q.acc <= `DTP_ACC_RST;
         st_q.phase <= `DTP_PHASE_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign phase_word = st_q.phase;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_ACC_STEP: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ##1 st_q.acc == $past(st_q.acc) + $past(step_word))
      else $error("accumulator did not advance by the step word");

   AST_ACC_CONT: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $changed(step_word) |=> st_q.acc == $past(st_q.acc, 2) + $past(step_word, 2)
         + $past(step_word))
      else $error("accumulator jumped when the step word changed");

   AST_PHASE_SUM: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ##1 phase_word == 14'($past(st_q.acc[`DTP_ACC_TOP:`DTP_ACC_PHASE_LSB])
         + $past(phase_shift_word)))
      else $error("phase output is not accumulator plus offset");

   COV_STEP_CHANGE: cover property (@(posedge ref_clk) disable iff (!arst_n)
      $changed(step_word) && step_word != `DTP_STEP_RST);

endmodule // dtp_accum

// ---- dtp_top.sv ----
// Tuning word and phase offset registers with an Avalon-MM slave and the synthesis core
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`include "dtp_regs.svh"

// Behaviour
// - The 48-bit step word is built from six byte registers, lowest index holding bits 7..0 and highest bits 47..40.
// - Bits 15..8, 23..16, 31..24 and 39..32 sit in the four byte registers after the lowest one.
// - The step word sets the synthesized frequency as a fraction of the system clock, larger word giving higher frequency.
// - After reset the step word is loaded with a default picked by the four start-up select inputs.
// - A new step word takes effect at once while the accumulator carries on without a phase jump.
// - A phase shift word shifts the output phase by the programmed amount.
// - Bits 7..0 of the phase shift word have their own byte register, higher bits the next one.
// - Software must accept a brief phase glitch at each 45 degree crossing when the phase shift changes.
module dtp_top
#(
   parameter logic [47:0] STARTUP_STEP = `DTP_STARTUP_STEP_DEF
)
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire dtp_pkg::dtp_avs_req_t avs_req,
   output dtp_pkg::dtp_avs_resp_t avs_resp,
   input wire logic startup_select_a,
   input wire logic startup_select_b,
   input wire logic startup_select_c,
   input wire logic startup_select_d,
   output logic [13:0] phase_word
);

   dtp_pkg::dtp_top_state_t st_q;
   dtp_pkg::dtp_top_state_t st_d;
   logic [9:0] req_idx;
   logic [13:0] core_phase;

   assign req_idx = avs_req.address[11:`DTP_IDX_LSB];

   // ----------------------------------------------------------------
   // Synthesis core
   // ----------------------------------------------------------------
   dtp_accum u_accum
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .step_word(st_q.step_word),
      .phase_shift_word(st_q.phase_shift_word),
      .phase_word(core_phase)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [31:0] rdata;
      st_d = st_q;
      rdata = `DTP_RDATA_RST;
      // Select pins are asynchronous, two stages before use
      st_d.sel_meta = {startup_select_d, startup_select_c, startup_select_b, startup_select_a};
      st_d.sel_sync = st_q.sel_meta;

      // Read mux, narrow fields in the low bits, rest zero
      for (int i = 0; i < `DTP_STEP_BYTES; i++)
      begin
         if (req_idx == `DTP_IDX_STEP_B0 + 10'(i))
         begin
            rdata[7:0] = st_q.step_word[8*i +: 8];
         end
      end
      if (req_idx == `DTP_IDX_PHASE_LO)
      begin
         rdata[7:0] = st_q.phase_shift_word[7:0];
      end
      if (req_idx == `DTP_IDX_PHASE_HI)
      begin
         rdata[5:0] = st_q.phase_shift_word[13:8];
      end
      if (req_idx == `DTP_IDX_READBACK)
      begin
         rdata[13:0] = core_phase;
      end

      unique case (st_q.fsm)
         dtp_pkg::DTP_INIT:
         begin
            // Bus held off until the strap default is in place
            st_d.resp.waitrequest = 1'b1;
            st_d.init_cnt = st_q.init_cnt + 2'h1;
            if (st_q.init_cnt == `DTP_SYNC_DONE)
            begin
               st_d.step_word = 48'(st_q.sel_sync * STARTUP_STEP);
               st_d.init_cnt = st_q.init_cnt;
               st_d.fsm = dtp_pkg::DTP_IDLE;
            end
         end
         dtp_pkg::DTP_IDLE:
         begin
            if (avs_req.read || avs_req.write)
            begin
               st_d.resp.waitrequest = 1'b0;
               st_d.resp.readdata = avs_req.read ? rdata : `DTP_RDATA_RST;
               st_d.fsm = dtp_pkg::DTP_ACK;
            end
         end
         dtp_pkg::DTP_ACK:
         begin
            // Master samples waitrequest low at this edge; write lands here
            if (avs_req.write && avs_req.byteenable[0])
            begin
               for (int i = 0; i < `DTP_STEP_BYTES; i++)
               begin
                  if (req_idx == `DTP_IDX_STEP_B0 + 10'(i))
                  begin
                     // Takes effect next cycle, no accumulator reset
                     st_d.step_word[8*i +: 8] = avs_req.writedata[7:0];
                  end
               end
               if (req_idx == `DTP_IDX_PHASE_LO)
               begin
                  // Applied at once; glitch at 45 degree steps is accepted
                  st_d.phase_shift_word[7:0] = avs_req.writedata[7:0];
               end
               if (req_idx == `DTP_IDX_PHASE_HI)
               begin
                  st_d.phase_shift_word[13:8] = avs_req.writedata[5:0];
               end
            end
            st_d.resp.waitrequest = 1'b1;
            st_d.resp.readdata = `DTP_RDATA_RST;
            st_d.fsm = dtp_pkg::DTP_IDLE;
         end
         default:
         begin
            st_d.resp.waitrequest = 1'b1;
            st_d.fsm = dtp_pkg::DTP_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q.fsm <= dtp_pkg::DTP_INIT;
         st_q.resp.waitrequest <= 1'b1;
         st_q.resp.readdata <= `DTP_RDATA_RST;
         st_q.step_word <= `DTP_STEP_RST;
         st_q.phase_shift_word <= `DTP_PHASE_RST;
         st_q.sel_meta <= 4'h0;
         st_q.sel_sync <= 4'h0;
         st_q.init_cnt <= 2'h0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign avs_resp = st_q.resp;
   assign phase_word = core_phase;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking dtp_cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   logic wr_hit;
   assign wr_hit = st_q.fsm == dtp_pkg::DTP_ACK && avs_req.write && avs_req.byteenable[0];

   AST_STEP_LOW: assert property (
      wr_hit && req_idx == `DTP_IDX_STEP_B0
      |=> st_q.step_word[7:0] == $past(avs_req.writedata[7:0])
         && st_q.step_word[47:8] == $past(st_q.step_word[47:8]))
      else $error("lowest step byte not written to bits 7..0");

   AST_STEP_TOP: assert property (
      wr_hit && req_idx == `DTP_IDX_STEP_B5
      |=> st_q.step_word[47:40] == $past(avs_req.writedata[7:0]))
      else $error("top step byte not written to bits 47..40");

   AST_STEP_MID: assert property (
      wr_hit && req_idx == `DTP_IDX_STEP_B2
      |=> st_q.step_word[23:16] == $past(avs_req.writedata[7:0])
         && st_q.step_word[15:0] == $past(st_q.step_word[15:0]))
      else $error("step byte 2 not written to bits 23..16");

   AST_STRAP_LOAD: assert property (
      st_q.fsm == dtp_pkg::DTP_INIT && st_q.init_cnt == `DTP_SYNC_DONE
      |=> st_q.step_word == 48'($past(st_q.sel_sync) * STARTUP_STEP)
         && st_q.fsm == dtp_pkg::DTP_IDLE)
      else $error("start-up default not loaded from select inputs");

   AST_PHASE_LO: assert property (
      wr_hit && req_idx == `DTP_IDX_PHASE_LO
      |=> st_q.phase_shift_word[7:0] == $past(avs_req.writedata[7:0]))
      else $error("phase shift low byte not written");

   AST_PHASE_HI: assert property (
      wr_hit && req_idx == `DTP_IDX_PHASE_HI
      |=> st_q.phase_shift_word[13:8] == $past(avs_req.writedata[5:0])
         && st_q.phase_shift_word[7:0] == $past(st_q.phase_shift_word[7:0]))
      else $error("phase shift upper six bits not written");

   // Carry out of the low accumulator bits may add one to the step
   AST_PHASE_APPLY: assert property (
      $changed(st_q.phase_shift_word) && $stable(st_q.step_word)
      |=> 14'(core_phase - $past(core_phase) - $past(st_q.phase_shift_word)
         + $past(st_q.phase_shift_word, 2) - $past(st_q.step_word[47:34])) <= 14'h0001)
      else $error("phase shift not applied to the output");

   AST_BUS_ANSWER: assert property (
      st_q.fsm == dtp_pkg::DTP_IDLE && (avs_req.read || avs_req.write)
      |=> !avs_resp.waitrequest ##1 avs_resp.waitrequest)
      else $error("bus answer not given after exactly one wait cycle");

   AST_INIT_HOLD: assert property (
      st_q.fsm == dtp_pkg::DTP_INIT |-> avs_resp.waitrequest)
      else $error("bus released before start-up load");

   COV_WRITE_STEP: cover property (wr_hit && req_idx == `DTP_IDX_STEP_B3);
   COV_WRITE_PHASE: cover property (wr_hit && req_idx == `DTP_IDX_PHASE_HI);
   COV_READBACK: cover property (
      st_q.fsm == dtp_pkg::DTP_IDLE && avs_req.read && req_idx == `DTP_IDX_READBACK);

endmodule // dtp_top

// ---- dtp_host.sv ----
// Avalon-MM host model that writes and reads the tuning registers
`timescale 1ns/100ps

module dtp_host
(
   input wire logic ref_clk,
   input wire dtp_pkg::dtp_avs_resp_t avs_resp,
   output dtp_pkg::dtp_avs_req_t avs_req
);
   initial avs_req = '0;

   // ----------------------------------------------------------------
   // Bus cycle
   // ----------------------------------------------------------------
   // Random idle gap so requests are spaced by either one or two idle cycles
   task automatic access(input logic we, input logic [9:0] idx, input logic [7:0] wd,
      input logic be0, output logic [31:0] rd);
      int gap;
      gap = $urandom_range(1, 0);
      repeat (gap) @(posedge ref_clk);
      @(posedge ref_clk);
      avs_req <= '{read: ~we, write: we, address: {idx, 2'h0}, byteenable: {3'h0, be0},
         writedata: {24'h0, wd}};
      do @(posedge ref_clk);
      while (avs_resp.waitrequest !== 1'b0);
      rd = avs_resp.readdata;
      avs_req <= '0;
   endtask
endmodule // dtp_host

// ---- dds_tuning_phase_regs_tb.sv ----
// Self-checking bench for the tuning and phase registers
`timescale 1ns/100ps
`include "dtp_regs.svh"

module dds_tuning_phase_regs_tb;
   logic ref_clk;
   logic arst_n;
   logic [3:0] sel;
   dtp_pkg::dtp_avs_req_t avs_req;
   dtp_pkg::dtp_avs_resp_t avs_resp;
   logic [13:0] phase_word;
   int error_cnt = 0;
   int n_compared = 0;
   int cyc = 0;
   logic rec = 1'b0;
   logic [13:0] hist[$];
   logic [7:0] mir[0:7];
   logic [31:0] rd;
   logic [13:0] pw0, pw1, pold, p, d;
   int c0, c1, j;
   logic [7:0] b;
   logic be, sw;
   logic [5:0] k1, k2;

   dtp_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .avs_req(avs_req),
      .avs_resp(avs_resp), .startup_select_a(sel[0]), .startup_select_b(sel[1]),
      .startup_select_c(sel[2]), .startup_select_d(sel[3]), .phase_word(phase_word));
   dtp_host host_u (.ref_clk(ref_clk), .avs_resp(avs_resp), .avs_req(avs_req));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Cycle count, phase history and hang guard
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (rec)
         hist.push_back(phase_word);
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
         $display("Error %0t: bus value %h, expected %h", $time, got, exp);
      if (got !== exp)
         error_cnt++;
   endtask

   task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
      n_compared++;
      if (got !== exp)
         $display("Error %0t: phase value %h, expected %h", $time, got, exp);
      if (got !== exp)
         error_cnt++;
   endtask

   function automatic logic [47:0] strap_default(input logic [3:0] s);
      return 48'(s * `DTP_STARTUP_STEP_DEF);
   endfunction

   // Settled phase after n steps of k with no low-bit carry, plus a shift change
   function automatic logic [13:0] phase_after(input logic [13:0] base, input logic [5:0] k,
      input int n, input logic [13:0] dp);
      return 14'(base + k * n + dp);
   endfunction

   task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
      logic [31:0] x;
      host_u.access(1'b1, idx, wd, 1'b1, x);
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
      host_u.access(1'b0, idx, 8'h00, 1'b1, rd);
      chk32(rd, exp);
   endtask

   task automatic snap(output logic [13:0] pw, output int c);
      @(posedge ref_clk);
      pw = phase_word;
      c = cyc;
   endtask

   task automatic do_reset(input logic [3:0] s);
      logic [47:0] def;
      def = strap_default(s);
      arst_n <= 1'b0;
      sel <= s;
      repeat (4) @(posedge ref_clk);
      chk32({avs_resp.waitrequest, avs_resp.readdata[30:0]}, 32'h8000_0000);
      chk14(phase_word, 14'h0000);
      arst_n <= 1'b1;
      pold = 14'h0000;
      for (int i = 0; i < 8; i++)
         mir[i] = (i < 6) ? def[8*i +: 8] : 8'h00;
      for (int i = 0; i < 6; i++)
         rdc(10'(`DTP_IDX_STEP_B0 + i), {24'h0, mir[i]});
   endtask

   task automatic print_verdict();
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      arst_n = 1'b0;
      sel = 4'h0;
      void'($urandom(32'hE050));
      do_reset(4'($urandom));
      // Random byte writes, some refused by a cleared byte enable
      for (int n = 0; n < 40; n++)
      begin
         j = $urandom_range(7, 0);
         b = 8'($urandom);
         be = 1'($urandom);
         host_u.access(1'b1, 10'(`DTP_IDX_STEP_B0 + j), b, be, rd);
         if (be)
            mir[j] = (j == 7) ? (b & 8'h3F) : b;
      end
      for (int i = 0; i < 8; i++)
         rdc(10'(`DTP_IDX_STEP_B0 + i), {24'h0, mir[i]});
      wr(10'h1A5, 8'hA5);
      rdc(10'h1A5, 32'h0000_0000);
      pold = {mir[7][5:0], mir[6]};
      // Steps that are multiples of the phase LSB give exact deltas
      // Low step bytes cleared so the top bits never take a carry
      for (int i = 0; i < 4; i++)
         wr(10'(`DTP_IDX_STEP_B0 + i), 8'h00);
      k1 = 6'h3F;
      wr(`DTP_IDX_STEP_B5, 8'h00);
      wr(`DTP_IDX_STEP_B4, {k1, 2'h0});
      // Old step must have left the phase history before recording
      repeat (4) @(posedge ref_clk);
      for (int t = 0; t < 5; t++)
      begin
         k2 = k1 + 6'($urandom_range(63, 1));
         hist.delete();
         rec = 1'b1;
         wr(`DTP_IDX_STEP_B4, {k2, 2'h0});
         repeat (6) @(posedge ref_clk);
         rec = 1'b0;
         sw = 1'b0;
         for (int i = 0; i + 1 < hist.size(); i++)
         begin
            d = hist[i+1] - hist[i];
            chk14(d, (sw || d == k2) ? {8'h00, k2} : {8'h00, k1});
            sw = sw | (d == k2);
         end
         chk14(d, {8'h00, k2});
         k1 = k2;
      end
      // Transients at the update are accepted; only settled phase is compared
      for (int t = 0; t < 5; t++)
      begin
         p = 14'($urandom);
         snap(pw0, c0);
         wr(`DTP_IDX_PHASE_LO, p[7:0]);
         wr(`DTP_IDX_PHASE_HI, {2'h0, p[13:8]});
         repeat (6) @(posedge ref_clk);
         snap(pw1, c1);
         chk14(pw1, phase_after(pw0, k1, c1 - c0, 14'(p - pold)));
         pold = p;
      end
      // Readback holds the phase one step older than the one standing now
      host_u.access(1'b0, `DTP_IDX_READBACK, 8'h00, 1'b1, rd);
      chk32(rd, {18'h0, phase_after(phase_word, k1, -1, 14'h0000)});
      do_reset(4'hF);
      print_verdict();
   end
endmodule // dds_tuning_phase_regs_tb
